// file: logic/kdc_cfg.svh
// Constants of the keypad and display controller: offsets, fields, timings.
// Assumes a 25 MHz clock and 32-bit APB data.
`ifndef KDC_CFG_SVH
`define KDC_CFG_SVH

`define KDC_CLK_KHZ 25000
`define KDC_VERSION_MS 2000
`define KDC_MSG_MS 1000
`define KDC_DEBOUNCE_MS 10
`define KDC_REPEAT_MS 50
`define KDC_FAST_STEP 8'h0a
`define KDC_TIMER_W 26

`define KDC_REG_CTRL 8'h00
`define KDC_REG_STATUS 8'h04
`define KDC_REG_INT_STAT 8'h08
`define KDC_REG_INT_MASK 8'h0c
`define KDC_REG_EDIT 8'h10

`define KDC_CTRL_LOCK 0
`define KDC_INT_W 4
`define KDC_INT_ALARM 0
`define KDC_INT_RETRY 1
`define KDC_INT_DONE 2
`define KDC_INT_REFUSED 3

`endif

// file: logic/kdc_pkg.sv
// Types shared by the keypad and display controller.
// Assumes nothing beyond the constants header.
package kdc_pkg;
	typedef enum logic [3:0] {
		value_message, version_message, idle_message, run_message,
		alarm_code_message, bus_low_message, done_message, reset_message,
		test_message, retry_message, param_label, bit_param_label,
		param_bit_label, program_step_label, bit_state_message
	} kdc_msg_t;
	typedef enum logic [1:0] {kind_decimal, kind_bit_param, kind_single_bit, kind_program_step}
		kdc_kind_t;
	typedef enum logic [1:0] {unit_speed, unit_accel, unit_position, unit_current} kdc_unit_t;
endpackage

// file: logic/kdc_top.sv
// Front-panel keypad scan, browse/edit control and status message selection.
// Assumes a parameter store answering combinationally to param_index, and APB.
//
// Overview of operation
// - Three keys only: mode, up and down; mode changes what up and down do.
// - Mode press toggles selection and value display; entry loads the value.
// - At power-up without alarm show idle or run at the speed status slot.
// - In selection mode up and down step the parameter index.
// - In value mode up and down increment or decrement the value.
// - Mode pressed while up or down held gives no toggle; fast change in value mode only.
// - After power-up show the version message for two seconds.
// - On alarm disable drive, jump to speed slot, show alarm code.
// - At speed slot show bus low when not low voltage, bus low, not ready.
// - Each command entered shows the done message for one second.
// - Each alarm clear command shows the reset message for one second.
// - While wiring test bit is set keep the test message shown.
// - Program store or parameter save write error shows the retry message.
// - Labels by kind; a single bit entry in value mode shows the bit state.
// - Values shown with fixed resolutions per unit via decimal point.
// - The speed slot label never appears; drive status shows instead.
// - With the lock bit set keypad modifications are refused.
//
// Our own choices: the address map and the APB interface to the registers.
`include "kdc_cfg.svh"

module kdc_top #(
	parameter int PARAM_COUNT = 128,
	parameter logic [7:0] SW_VERSION = 8'h01, // Arbitrary value
	parameter int VERSION_CYCLES = `KDC_VERSION_MS * `KDC_CLK_KHZ,
	parameter int MSG_CYCLES = `KDC_MSG_MS * `KDC_CLK_KHZ,
	parameter int DEBOUNCE_CYCLES = `KDC_DEBOUNCE_MS * `KDC_CLK_KHZ,
	parameter int REPEAT_CYCLES = `KDC_REPEAT_MS * `KDC_CLK_KHZ
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Keys
	input wire logic key_mode,
	input wire logic key_up,
	input wire logic key_down,
	// Drive status
	input wire logic drive_enabled,
	input wire logic alarm_active,
	input wire logic [7:0] alarm_code,
	input wire logic low_voltage_operation_bit,
	input wire logic dc_bus_low,
	input wire logic drive_ready_bit,
	input wire logic wiring_test_bit,
	input wire logic command_entered,
	input wire logic alarm_clear_cmd,
	input wire logic program_store_error,
	input wire logic parameter_save_error,
	output logic drive_disable,
	// Parameter store
	output logic [7:0] param_index,
	input wire logic signed [15:0] param_rd_data,
	input wire logic signed [15:0] param_min,
	input wire logic signed [15:0] param_max,
	input wire kdc_pkg::kdc_kind_t param_kind,
	input wire logic [3:0] param_bit_pos,
	input wire kdc_pkg::kdc_unit_t param_unit,
	output logic param_wr,
	output logic signed [15:0] param_wr_data,
	// Display
	output kdc_pkg::kdc_msg_t disp_msg,
	output logic [7:0] disp_num,
	output logic signed [15:0] disp_value,
	output logic [3:0] disp_bit,
	output logic [1:0] disp_point,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq
);
	localparam int TW = `KDC_TIMER_W;

	logic [2:0] key_raw;
	logic [2:0] stable;
	logic [2:0] stable_q;
	logic [2:0] press;
	logic value_mode;
	logic fast_on;
	logic fast_dir;
	logic signed [15:0] edit_value;
	logic parameter_lock_bit;
	logic lock_refused;
	logic alarm_q;
	logic alarm_rise;
	logic [TW-1:0] version_cnt;
	logic [TW-1:0] done_cnt;
	logic [TW-1:0] reset_cnt;
	logic [TW-1:0] rep_cnt;
	logic rep_tick;
	logic retry_on;
	logic [`KDC_INT_W-1:0] int_stat;
	logic [`KDC_INT_W-1:0] int_mask;
	logic [`KDC_INT_W-1:0] events;
	logic apb_access;
	logic apb_wr;
	logic [31:0] rd_mux;
	kdc_pkg::kdc_msg_t next_msg;
	logic [7:0] next_num;
	logic signed [15:0] next_value;

	function automatic logic signed [15:0] step_val(input logic signed [15:0] v,
		input logic signed [15:0] mn, input logic signed [15:0] mx,
		input logic dn, input logic [7:0] amt);
		logic signed [16:0] s;
		s = dn ? ({v[15], v} - $signed({9'h000, amt})) : ({v[15], v} + $signed({9'h000, amt}));
		if (s > $signed({mx[15], mx}))
			step_val = mx;
		else if (s < $signed({mn[15], mn}))
			step_val = mn;
		else
			step_val = s[15:0];
	endfunction

	function automatic logic [1:0] unit_point(input kdc_pkg::kdc_unit_t u);
		unique case (u)
			kdc_pkg::unit_accel: unit_point = 2'h3;
			kdc_pkg::unit_current: unit_point = 2'h1;
			kdc_pkg::unit_speed, kdc_pkg::unit_position: unit_point = 2'h0;
		endcase
	endfunction

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = a == `KDC_REG_CTRL || a == `KDC_REG_STATUS || a == `KDC_REG_INT_STAT ||
			a == `KDC_REG_INT_MASK || a == `KDC_REG_EDIT;
	endfunction

	// Key synchroniser and debounce, one per key
	assign key_raw = {key_down, key_up, key_mode};
	for (genvar g = 0; g < 3; g++)
	begin : deb
		logic s1;
		logic s2;
		logic st;
		logic [TW-1:0] cnt;
		always_ff @(posedge clock)
		begin
			if (sys_rst)
			begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				st <= 1'b0;
				cnt <= '0;
			end
			else
			begin
				s1 <= key_raw[g];
				s2 <= s1;
				if (s2 == st)
					cnt <= '0;
				else if (cnt == TW'(DEBOUNCE_CYCLES - 1))
				begin
					st <= s2;
					cnt <= '0;
				end
				else
					cnt <= cnt + 1'b1;
			end
		end
		assign stable[g] = st;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			stable_q <= '0;
			alarm_q <= 1'b0;
			drive_disable <= 1'b0;
		end
		else
		begin
			stable_q <= stable;
			alarm_q <= alarm_active;
			drive_disable <= alarm_active;
		end
	end
	assign press = stable & ~stable_q;
	assign alarm_rise = alarm_active & ~alarm_q;

	// Repeat rate while fast change is active
	always_ff @(posedge clock)
	begin
		if (sys_rst || !fast_on || rep_tick)
			rep_cnt <= '0;
		else
			rep_cnt <= rep_cnt + 1'b1;
	end
	assign rep_tick = fast_on && rep_cnt == TW'(REPEAT_CYCLES - 1);

	// Browse and edit control
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			value_mode <= 1'b0;
			param_index <= 8'h00;
			edit_value <= 16'h0000;
			fast_on <= 1'b0;
			fast_dir <= 1'b0;
			param_wr <= 1'b0;
			param_wr_data <= 16'h0000;
			lock_refused <= 1'b0;
		end
		else
		begin
			param_wr <= 1'b0;
			lock_refused <= 1'b0;
			if (alarm_rise)
			begin
				value_mode <= 1'b0;
				param_index <= 8'h00;
				fast_on <= 1'b0;
			end
			else if (press[0])
			begin
				if (stable[1] || stable[2])
				begin
					fast_on <= value_mode;
					fast_dir <= stable[2];
				end
				else
				begin
					value_mode <= ~value_mode;
					if (!value_mode)
						edit_value <= param_rd_data;
				end
			end
			else if (fast_on)
			begin
				if (!(fast_dir ? stable[2] : stable[1]))
					fast_on <= 1'b0;
				else if (rep_tick)
				begin
					if (parameter_lock_bit)
						lock_refused <= 1'b1;
					else
					begin
						edit_value <= step_val(edit_value, param_min, param_max, fast_dir,
							`KDC_FAST_STEP);
						param_wr <= 1'b1;
						param_wr_data <= step_val(edit_value, param_min, param_max, fast_dir,
							`KDC_FAST_STEP);
					end
				end
			end
			else if (press[1] || press[2])
			begin
				if (!value_mode)
				begin
					if (press[1])
						param_index <= (param_index == 8'(PARAM_COUNT - 1)) ? 8'h00 :
							param_index + 8'h01;
					else
						param_index <= (param_index == 8'h00) ? 8'(PARAM_COUNT - 1) :
							param_index - 8'h01;
				end
				else if (parameter_lock_bit)
					lock_refused <= 1'b1;
				else
				begin
					edit_value <= step_val(edit_value, param_min, param_max, press[2],
						8'h01);
					param_wr <= 1'b1;
					param_wr_data <= step_val(edit_value, param_min, param_max, press[2], 8'h01);
				end
			end
		end
	end

	// Message timers
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			version_cnt <= TW'(VERSION_CYCLES);
			done_cnt <= '0;
			reset_cnt <= '0;
			retry_on <= 1'b0;
		end
		else
		begin
			if (version_cnt != '0)
				version_cnt <= version_cnt - 1'b1;
			if (command_entered || alarm_clear_cmd)
				done_cnt <= TW'(MSG_CYCLES);
			else if (done_cnt != '0)
				done_cnt <= done_cnt - 1'b1;
			if (alarm_clear_cmd)
				reset_cnt <= TW'(MSG_CYCLES);
			else if (reset_cnt != '0)
				reset_cnt <= reset_cnt - 1'b1;
			if (program_store_error || parameter_save_error)
				retry_on <= 1'b1;
			else if (|press)
				retry_on <= 1'b0;
		end
	end

	// Display selection, highest priority first
	always_comb
	begin
		next_msg = kdc_pkg::value_message;
		next_num = param_index;
		next_value = edit_value;
		if (version_cnt != '0)
		begin
			next_msg = kdc_pkg::version_message;
			next_num = SW_VERSION;
		end
		else if (wiring_test_bit)
			next_msg = kdc_pkg::test_message;
		else if (retry_on)
			next_msg = kdc_pkg::retry_message;
		else if (reset_cnt != '0)
			next_msg = kdc_pkg::reset_message;
		else if (done_cnt != '0)
			next_msg = kdc_pkg::done_message;
		else if (param_index == 8'h00)
		begin
			if (alarm_active)
			begin
				next_msg = kdc_pkg::alarm_code_message;
				next_num = alarm_code;
			end
			else if (!low_voltage_operation_bit && dc_bus_low && !drive_ready_bit)
				next_msg = kdc_pkg::bus_low_message;
			else
				next_msg = drive_enabled ? kdc_pkg::run_message :
					kdc_pkg::idle_message;
		end
		else if (value_mode)
		begin
			if (param_kind == kdc_pkg::kind_single_bit)
			begin
				next_msg = kdc_pkg::bit_state_message;
				next_value = {15'h0000, edit_value[0]};
			end
		end
		else
		begin
			unique case (param_kind)
				kdc_pkg::kind_decimal: next_msg = kdc_pkg::param_label;
				kdc_pkg::kind_bit_param: next_msg = kdc_pkg::bit_param_label;
				kdc_pkg::kind_single_bit: next_msg = kdc_pkg::param_bit_label;
				kdc_pkg::kind_program_step: next_msg = kdc_pkg::program_step_label;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			disp_msg <= kdc_pkg::version_message;
			disp_num <= 8'h00;
			disp_value <= 16'h0000;
			disp_bit <= 4'h0;
			disp_point <= 2'h0;
		end
		else
		begin
			disp_msg <= next_msg;
			disp_num <= next_num;
			disp_value <= next_value;
			disp_bit <= param_bit_pos;
			disp_point <= unit_point(param_unit);
		end
	end

	// APB slave: one wait state, writes land at the completing edge
	assign apb_access = psel && penable && !pready;
	assign apb_wr = psel && penable && pready && pwrite;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`KDC_REG_CTRL: rd_mux[`KDC_CTRL_LOCK] = parameter_lock_bit;
			`KDC_REG_STATUS: rd_mux = {12'h000, disp_msg, fast_on, value_mode, 6'h00, param_index};
			`KDC_REG_INT_STAT: rd_mux[`KDC_INT_W-1:0] = int_stat;
			`KDC_REG_INT_MASK: rd_mux[`KDC_INT_W-1:0] = int_mask;
			`KDC_REG_EDIT: rd_mux = {{16{edit_value[15]}}, edit_value};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= apb_access;
			if (apb_access)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !addr_hit(paddr);
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			parameter_lock_bit <= 1'b0;
			int_mask <= '0;
		end
		else if (apb_wr && paddr == `KDC_REG_CTRL)
			parameter_lock_bit <= pwdata[`KDC_CTRL_LOCK];
		else if (apb_wr && paddr == `KDC_REG_INT_MASK)
			int_mask <= pwdata[`KDC_INT_W-1:0];
	end

	// Sticky events; a new event beats a write-one clear
	assign events = {lock_refused, command_entered, program_store_error || parameter_save_error,
		alarm_rise};
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			int_stat <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (apb_wr && paddr == `KDC_REG_INT_STAT)
				int_stat <= (int_stat & ~pwdata[`KDC_INT_W-1:0]) | events;
			else
				int_stat <= int_stat | events;
			irq <= |(int_stat & int_mask);
		end
	end

	a_version_first: assert property (@(posedge clock) $fell(sys_rst) |-> disp_msg ==
		kdc_pkg::version_message) else $error("version message missing after reset");
	a_alarm_slot: assert property (@(posedge clock) disable iff (sys_rst)
		alarm_rise |=> param_index == 8'h00 && !value_mode) else $error("alarm did not jump");
	a_drive_off: assert property (@(posedge clock) disable iff (sys_rst)
		alarm_active |=> drive_disable) else $error("drive not disabled on alarm");
	a_test_shown: assert property (@(posedge clock) disable iff (sys_rst)
		wiring_test_bit && version_cnt == '0 |=> disp_msg == kdc_pkg::test_message)
		else $error("test message not shown");
	a_lock_blocks: assert property (@(posedge clock) disable iff (sys_rst)
		parameter_lock_bit |=> !param_wr) else $error("write while locked");
	a_select_step: assert property (@(posedge clock) disable iff (sys_rst)
		!value_mode && press[1] && !press[0] && !fast_on && !alarm_rise &&
		param_index < 8'(PARAM_COUNT - 1) |=> param_index == $past(param_index) + 8'h01)
		else $error("index did not step");
	a_value_clamp: assert property (@(posedge clock) disable iff (sys_rst)
		value_mode && press[1] && !press[0] && !fast_on && !alarm_rise &&
		edit_value == param_max |=> edit_value == $past(edit_value))
		else $error("value passed maximum");
	a_mode_toggle: assert property (@(posedge clock) disable iff (sys_rst)
		press[0] && !stable[1] && !stable[2] && !alarm_rise |=> value_mode != $past(value_mode))
		else $error("mode key did not toggle");
	a_fast_hold: assert property (@(posedge clock) disable iff (sys_rst)
		press[0] && (stable[1] || stable[2]) && !alarm_rise |=> value_mode == $past(value_mode))
		else $error("mode toggled during fast change");
	a_done_shown: assert property (@(posedge clock) disable iff (sys_rst)
		command_entered |=> done_cnt == TW'(MSG_CYCLES) ##1 done_cnt != '0)
		else $error("done timer not started");
	a_slot_label: assert property (@(posedge clock) disable iff (sys_rst)
		param_index == 8'h00 |=> disp_msg != kdc_pkg::param_label)
		else $error("speed slot label shown");
	a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
		|(int_stat & int_mask) |=> irq) else $error("interrupt not raised");
endmodule

// file: verification/kdc_panel_model.sv
// Panel model: drives the three keys and holds the parameter store.
// Assumes the design reads the store in the same cycle as param_index.
module kdc_panel_model (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Keys
	output logic key_mode,
	output logic key_up,
	output logic key_down,
	// Parameter store
	input wire logic [7:0] param_index,
	input wire logic param_wr,
	input wire logic signed [15:0] param_wr_data,
	output logic signed [15:0] param_rd_data,
	output logic signed [15:0] param_min,
	output logic signed [15:0] param_max,
	output kdc_pkg::kdc_kind_t param_kind,
	output logic [3:0] param_bit_pos,
	output kdc_pkg::kdc_unit_t param_unit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [15:0] store [0:255];
	initial {key_mode, key_up, key_down} = 3'b000;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 256; i++)
				store[i] <= 16'sh0000;
		end
		else if (param_wr)
			store[param_index] <= param_wr_data;
	end
	// Kind from the low index bits, unit from the next two
	assign param_rd_data = store[param_index];
	assign param_min = -16'sd100;
	assign param_max = 16'sd100;
	assign param_kind = kdc_pkg::kdc_kind_t'(param_index[1:0]);
	assign param_unit = kdc_pkg::kdc_unit_t'(param_index[3:2]);
	assign param_bit_pos = param_index[3:0];
	// Keys {mode, up, down} change just after an edge and stand n cycles
	task automatic set_keys(input logic [2:0] k, input int n);
		@(posedge clock);
		{key_mode, key_up, key_down} <= k;
		repeat (n) @(posedge clock);
	endtask
endmodule

// file: verification/test_keypad_display_controller.sv
// Self-checking bench of the keypad and display controller.
// Assumes shortened timers: version 200, messages 100, debounce 4, repeat 8.
`include "kdc_cfg.svh"
module test_keypad_display_controller;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int VC = 200;
	localparam int MC = 100;
	localparam logic [7:0] VER = 8'h5c; // Arbitrary value
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic drive_enabled = 1'b0;
	logic alarm_active = 1'b0;
	logic [7:0] alarm_code = 8'h00;
	logic dc_bus_low = 1'b0;
	logic low_voltage_operation_bit = 1'b0;
	logic drive_ready_bit = 1'b0;
	logic wiring_test_bit = 1'b0;
	logic [3:0] evt = 4'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic key_mode, key_up, key_down, drive_disable, param_wr, pready, pslverr, irq, e;
	logic [7:0] param_index, disp_num;
	logic signed [15:0] param_rd_data, param_min, param_max, param_wr_data, disp_value;
	kdc_pkg::kdc_kind_t param_kind;
	kdc_pkg::kdc_unit_t param_unit;
	kdc_pkg::kdc_msg_t disp_msg;
	logic [3:0] param_bit_pos, disp_bit;
	logic [1:0] disp_point;
	logic [31:0] prdata, r;
	int num_errors = 0;
	int checks = 0;
	int wr_count = 0;
	int n;

	always #20 clock = ~clock;
	always @(posedge clock)
		if (param_wr === 1'b1)
			wr_count++;

	kdc_top #(.SW_VERSION(VER), .VERSION_CYCLES(VC), .MSG_CYCLES(MC), .DEBOUNCE_CYCLES(4),
		.REPEAT_CYCLES(8))
	kdc_top_inst (.clock(clock), .sys_rst(sys_rst), .key_mode(key_mode), .key_up(key_up),
		.key_down(key_down), .drive_enabled(drive_enabled), .alarm_active(alarm_active),
		.alarm_code(alarm_code), .low_voltage_operation_bit(low_voltage_operation_bit),
		.dc_bus_low(dc_bus_low),
		.drive_ready_bit(drive_ready_bit), .wiring_test_bit(wiring_test_bit),
		.command_entered(evt[0]), .alarm_clear_cmd(evt[1]), .program_store_error(evt[2]),
		.parameter_save_error(evt[3]), .drive_disable(drive_disable),
		.param_index(param_index), .param_rd_data(param_rd_data), .param_min(param_min),
		.param_max(param_max), .param_kind(param_kind), .param_bit_pos(param_bit_pos),
		.param_unit(param_unit), .param_wr(param_wr), .param_wr_data(param_wr_data),
		.disp_msg(disp_msg), .disp_num(disp_num), .disp_value(disp_value),
		.disp_bit(disp_bit), .disp_point(disp_point), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));

	kdc_panel_model kdc_panel_model_inst (.clock(clock), .sys_rst(sys_rst),
		.key_mode(key_mode), .key_up(key_up), .key_down(key_down),
		.param_index(param_index), .param_wr(param_wr), .param_wr_data(param_wr_data),
		.param_rd_data(param_rd_data), .param_min(param_min), .param_max(param_max),
		.param_kind(param_kind), .param_bit_pos(param_bit_pos), .param_unit(param_unit));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1'b1, pready);
	endtask

	// Keys {mode, up, down}: press, then release
	task automatic hit(input logic [2:0] k);
		kdc_panel_model_inst.set_keys(k, 12);
		kdc_panel_model_inst.set_keys(3'b000, 12);
	endtask

	task automatic ev(input int i);
		@(posedge clock);
		evt[i] <= 1'b1;
		@(posedge clock);
		evt[i] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	task automatic t_power();
		chk("msg", kdc_pkg::version_message, disp_msg);
		repeat (VC - 10) @(posedge clock);
		chk("msg", kdc_pkg::version_message, disp_msg);
		chk("num", VER, disp_num);
		repeat (20) @(posedge clock);
		chk("msg", kdc_pkg::idle_message, disp_msg);
		drive_enabled <= 1'b1;
		repeat (3) @(posedge clock);
		chk("msg", kdc_pkg::run_message, disp_msg);
		apb(1'b0, `KDC_REG_CTRL, 32'h0);
		chk("ctrl", 32'h0, r);
		apb(1'b0, `KDC_REG_INT_MASK, 32'h0);
		chk("mask", 32'h0, r);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 1'b1, e);
		$display("t_power end");
	endtask

	task automatic t_browse();
		hit(3'b010);
		chk("index", 8'h01, param_index);
		chk("msg", kdc_pkg::bit_param_label, disp_msg);
		hit(3'b010);
		chk("msg", kdc_pkg::param_bit_label, disp_msg);
		chk("bit", 4'h2, disp_bit);
		hit(3'b100);
		chk("msg", kdc_pkg::bit_state_message, disp_msg);
		hit(3'b100);
		chk("msg", kdc_pkg::param_bit_label, disp_msg);
		repeat (3) hit(3'b001);
		chk("index", 8'h7f, param_index);
		chk("point", 2'h1, disp_point);
		repeat (4) hit(3'b010);
		chk("msg", kdc_pkg::program_step_label, disp_msg);
		hit(3'b010);
		chk("msg", kdc_pkg::param_label, disp_msg);
		$display("t_browse end");
	endtask

	task automatic t_edit();
		hit(3'b100);
		chk("msg", kdc_pkg::value_message, disp_msg);
		chk("point", 2'h3, disp_point);
		n = wr_count;
		hit(3'b010);
		chk("writes", n + 1, wr_count);
		chk("wr_data", 16'h0001, $unsigned(param_wr_data));
		kdc_panel_model_inst.set_keys(3'b001, 12);
		kdc_panel_model_inst.set_keys(3'b101, 200);
		kdc_panel_model_inst.set_keys(3'b000, 12);
		chk("wr_data", 16'hff9c, $unsigned(param_wr_data));
		chk("msg", kdc_pkg::value_message, disp_msg);
		hit(3'b010);
		chk("wr_data", 16'hff9d, $unsigned(param_wr_data));
		chk("value", 16'hff9d, $unsigned(disp_value));
		kdc_panel_model_inst.set_keys(3'b010, 12);
		kdc_panel_model_inst.set_keys(3'b110, 200);
		kdc_panel_model_inst.set_keys(3'b000, 12);
		chk("wr_data", 16'h0064, $unsigned(param_wr_data));
		hit(3'b010);
		chk("wr_data", 16'h0064, $unsigned(param_wr_data));
		chk("value", 16'h0064, $unsigned(disp_value));
		$display("t_edit end");
	endtask

	task automatic t_lock();
		apb(1'b1, `KDC_REG_CTRL, 32'h1);
		n = wr_count;
		hit(3'b010);
		chk("writes", n, wr_count);
		apb(1'b0, `KDC_REG_INT_STAT, 32'h0);
		chk("refused", 1'b1, r[3]);
		apb(1'b1, `KDC_REG_INT_MASK, 32'h8);
		repeat (3) @(posedge clock);
		chk("irq", 1'b1, irq);
		apb(1'b1, `KDC_REG_INT_STAT, 32'h8);
		repeat (3) @(posedge clock);
		chk("irq", 1'b0, irq);
		apb(1'b1, `KDC_REG_CTRL, 32'h0);
		hit(3'b100);
		chk("msg", kdc_pkg::param_label, disp_msg);
		$display("t_lock end");
	endtask

	task automatic t_status();
		alarm_code <= 8'h2a;
		alarm_active <= 1'b1;
		repeat (4) @(posedge clock);
		chk("disable", 1'b1, drive_disable);
		chk("index", 8'h00, param_index);
		chk("msg", kdc_pkg::alarm_code_message, disp_msg);
		chk("num", 8'h2a, disp_num);
		apb(1'b0, `KDC_REG_INT_STAT, 32'h0);
		chk("alarm_int", 1'b1, r[0]);
		alarm_active <= 1'b0;
		dc_bus_low <= 1'b1;
		repeat (4) @(posedge clock);
		chk("msg", kdc_pkg::bus_low_message, disp_msg);
		low_voltage_operation_bit <= 1'b1;
		repeat (4) @(posedge clock);
		chk("msg", kdc_pkg::run_message, disp_msg);
		low_voltage_operation_bit <= 1'b0;
		drive_ready_bit <= 1'b1;
		repeat (4) @(posedge clock);
		chk("msg", kdc_pkg::run_message, disp_msg);
		dc_bus_low <= 1'b0;
		ev(0);
		chk("msg", kdc_pkg::done_message, disp_msg);
		repeat (MC) @(posedge clock);
		chk("msg", kdc_pkg::run_message, disp_msg);
		ev(1);
		chk("msg", kdc_pkg::reset_message, disp_msg);
		repeat (MC) @(posedge clock);
		wiring_test_bit <= 1'b1;
		repeat (MC + 50) @(posedge clock);
		chk("msg", kdc_pkg::test_message, disp_msg);
		wiring_test_bit <= 1'b0;
		for (int i = 2; i < 4; i++)
		begin
			ev(i);
			chk("msg", kdc_pkg::retry_message, disp_msg);
			hit(3'b010);
			hit(3'b001);
		end
		chk("msg", kdc_pkg::run_message, disp_msg);
		$display("t_status end");
	endtask

	initial
	begin
		#300000;
		num_errors++;
		complete_run();
	end

	initial
	begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_power();
		t_browse();
		t_edit();
		t_lock();
		t_status();
		complete_run();
	end
endmodule
